// >>> design/gpibrl_pkg.sv
// constants and types for the listener remote/local control block
// assumes one 20 MHz system clock and an AXI4-Lite register bus
package gpibrl_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;

    // ------------------------------------------------------------
    // interface commands, seven low data lines only
    // ------------------------------------------------------------
    localparam logic [6:0] CMD_GTL   = 7'h01;
    localparam logic [6:0] CMD_SDC   = 7'h04;
    localparam logic [6:0] CMD_LLO   = 7'h11;
    localparam logic [6:0] CMD_DCL   = 7'h14;
    localparam logic [6:0] CMD_UNL   = 7'h3f;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [6:0] DATA_MASK  = 7'h7f;

    // ------------------------------------------------------------
    // program code characters
    // ------------------------------------------------------------
    localparam logic [6:0] CH_A     = 7'h41;
    localparam logic [6:0] CH_P     = 7'h50;
    localparam logic [6:0] CH_D     = 7'h44;
    localparam logic [6:0] CH_B     = 7'h42;
    localparam logic [6:0] CH_M     = 7'h4d;
    localparam logic [6:0] CH_V     = 7'h56;
    localparam logic [6:0] CH_MINUS = 7'h2d;
    localparam logic [6:0] CH_POINT = 7'h2e;
    localparam logic [6:0] CH_0     = 7'h30;
    localparam logic [6:0] CH_9     = 7'h39;
    localparam logic [6:0] CH_LOW_A = 7'h61;
    localparam logic [6:0] CH_LOW_Z = 7'h7a;
    localparam logic [6:0] CASE_FOLD = 7'h5f;

    // ------------------------------------------------------------
    // amplitude, signed tenths of a dB
    // ------------------------------------------------------------
    localparam logic [15:0] AMP_INIT = 16'hfb0a; // -127.0 dBm

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_AMPL   = 8'h08;
    localparam logic [4:0] CTRL_ADDR_RESET = 5'h07;
    localparam int ST_REMOTE  = 0;
    localparam int ST_ADDR    = 1;
    localparam int ST_LOCKOUT = 2;
    localparam int ST_DBMV    = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // front panel
    // ------------------------------------------------------------
    localparam int NUM_KEYS = 16;

    typedef enum logic [2:0] {
        P_IDLE, P_A, P_NUM, P_D, P_DB, P_DBM
    } gpibrl_pstate_e;

endpackage : gpibrl_pkg

// >>> design/gpibrl_cmd_decode.sv
// byte classifier for bytes taken from the bus
// assumes the acceptor handshake delivers one strobe per byte
`timescale 1ns/1ns
module gpibrl_cmd_decode
    import gpibrl_pkg::*;
(
    // byte from bus
    input  wire logic [7:0] busData,
    input  wire logic       busAtn,
    input  wire logic       busStrobe,
    input  wire logic [4:0] myAddr,
    // classified
    output logic            cmdGtl,
    output logic            cmdSdc,
    output logic            cmdLlo,
    output logic            cmdDcl,
    output logic            cmdUnl,
    output logic            listenMine,
    output logic            listenOther,
    output logic            dataValid,
    output logic [6:0]      dataChar
);
    logic [6:0] low7;
    logic       cmdByte;

    always_comb begin
        low7    = busData[6:0] & DATA_MASK;
        cmdByte = busStrobe & busAtn;
        cmdGtl  = cmdByte & (low7 == CMD_GTL);
        cmdSdc  = cmdByte & (low7 == CMD_SDC);
        cmdLlo  = cmdByte & (low7 == CMD_LLO);
        cmdDcl  = cmdByte & (low7 == CMD_DCL);
        cmdUnl  = cmdByte & (low7 == CMD_UNL);
        // talk, poll, trigger and control bytes fall through unused
        listenMine  = cmdByte & (low7[6:5] == GRP_LISTEN) & (low7[4:0] == myAddr) &
                      (low7 != CMD_UNL);
        listenOther = cmdByte & (low7[6:5] == GRP_LISTEN) & (low7[4:0] != myAddr) &
                      (low7 != CMD_UNL);
        dataValid = busStrobe & ~busAtn;
        if (low7 >= CH_LOW_A && low7 <= CH_LOW_Z) begin
            dataChar = low7 & CASE_FOLD;
        end else begin
            dataChar = low7;
        end
    end
endmodule : gpibrl_cmd_decode

// >>> design/gpibrl_listener.sv
// listener remote/local control with front panel gating and amplitude code parser
// assumes bus lines and keys are synchronous to sys_clk, one strobe per byte
`timescale 1ns/1ns
module gpibrl_listener
    import gpibrl_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // bus lines
    input  wire logic                busRen,
    input  wire logic                busIfc,
    input  wire logic                busAtn,
    input  wire logic                busStrobe,
    input  wire logic [7:0]          busData,
    // front panel
    input  wire logic [NUM_KEYS-1:0] keyPress,
    input  wire logic                localKey,
    input  wire logic                powerResetSwitch,
    output logic [NUM_KEYS-1:0]      keyAccept,
    output logic                     remoteIndicator,
    output logic                     addressedIndicator,
    output logic                     dbIndicator,
    output logic                     mvIndicator,
    output logic                     dbmIndicator,
    output logic [15:0]              amplitude,
    // axi4-lite write
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    // ------------------------------------------------------------
    // byte decode
    // ------------------------------------------------------------
    logic       cmdGtl, cmdSdc, cmdLlo, cmdDcl, cmdUnl;
    logic       listenMine, listenOther, dataValid;
    logic [6:0] dataChar;
    logic [4:0] myAddr;

    gpibrl_cmd_decode u_decode (
        .busData     (busData),
        .busAtn      (busAtn),
        .busStrobe   (busStrobe),
        .myAddr      (myAddr),
        .cmdGtl      (cmdGtl),
        .cmdSdc      (cmdSdc),
        .cmdLlo      (cmdLlo),
        .cmdDcl      (cmdDcl),
        .cmdUnl      (cmdUnl),
        .listenMine  (listenMine),
        .listenOther (listenOther),
        .dataValid   (dataValid),
        .dataChar    (dataChar)
    );

    // ------------------------------------------------------------
    // remote/local state and parser
    // ------------------------------------------------------------
    gpibrl_pstate_e  pState, next_pState;
    logic            lockout, next_lockout;
    logic            next_remote, next_addressed;
    logic            next_db, next_mv, next_dbm;
    logic [15:0]     next_amplitude;
    logic [15:0]     acc, next_acc;
    logic            neg, next_neg, point, next_point, frac, next_frac;
    logic [NUM_KEYS-1:0] next_keyAccept;
    logic            cmdClear, dataTaken, gtlTaken;
    logic [15:0]     applied;

    function automatic logic [15:0] times10(input logic [15:0] v);
        times10 = {v[12:0], 3'h0} + {v[14:0], 1'h0};
    endfunction : times10

    always_comb begin
        cmdClear  = cmdDcl | (cmdSdc & addressedIndicator);
        gtlTaken  = cmdGtl & addressedIndicator;
        dataTaken = dataValid & addressedIndicator;
        applied   = frac ? acc : times10(acc);
        if (neg) begin
            applied = 16'h0000 - applied;
        end
        next_remote    = remoteIndicator;
        next_addressed = addressedIndicator;
        next_lockout   = lockout;
        next_db        = dbIndicator;
        next_mv        = mvIndicator;
        next_dbm       = dbmIndicator;
        next_amplitude = amplitude;
        next_pState    = pState;
        next_acc       = acc;
        next_neg       = neg;
        next_point     = point;
        next_frac      = frac;
        // panel keys pass only in local, judged on the current state
        next_keyAccept = remoteIndicator ? '0 : keyPress;
        if (powerResetSwitch) begin
            next_remote    = 1'b0;
            next_addressed = 1'b0;
            next_lockout   = 1'b0;
            next_db        = 1'b0;
            next_mv        = 1'b0;
            next_dbm       = 1'b1;
            next_amplitude = AMP_INIT;
            next_pState    = P_IDLE;
        end else begin
            if (listenMine) begin
                next_addressed = 1'b1;
                if (busRen) begin
                    next_remote = 1'b1;
                end
            end
            if (listenOther || cmdUnl) begin
                next_addressed = 1'b0;
            end
            if (cmdLlo && busRen) begin
                next_lockout = 1'b1;
            end
            if (gtlTaken) begin
                next_remote = 1'b0;
            end
            if (localKey && remoteIndicator && !lockout) begin
                next_remote = 1'b0;
            end
            if (cmdClear) begin
                next_amplitude = AMP_INIT;
                next_db        = 1'b0;
                next_mv        = 1'b0;
                next_dbm       = 1'b1;
                next_pState    = P_IDLE;
            end
            // only the amplitude code is decoded in this block
            if (dataTaken) begin
                next_pState = P_IDLE;
                case (pState)
                    P_IDLE: begin
                        if (dataChar == CH_A) next_pState = P_A;
                    end
                    P_A: begin
                        if (dataChar == CH_P) begin
                            next_pState = P_NUM;
                            next_acc    = 16'h0000;
                            next_neg    = 1'b0;
                            next_point  = 1'b0;
                            next_frac   = 1'b0;
                        end
                    end
                    P_NUM: begin
                        next_pState = P_NUM;
                        if (dataChar >= CH_0 && dataChar <= CH_9) begin
                            // digits past the first decimal are dropped
                            if (!frac) begin
                                next_acc  = times10(acc) + {9'h000, dataChar - CH_0};
                                next_frac = point;
                            end
                        end else if (dataChar == CH_MINUS) begin
                            next_neg = 1'b1;
                        end else if (dataChar == CH_POINT) begin
                            next_point = 1'b1;
                        end else if (dataChar == CH_D) begin
                            next_pState = P_D;
                        end else begin
                            next_pState = P_IDLE;
                        end
                    end
                    P_D: begin
                        if (dataChar == CH_B) begin
                            next_pState = P_DB;
                        end else if (dataChar == CH_M) begin
                            next_amplitude = applied;
                            next_db        = 1'b0;
                            next_mv        = 1'b0;
                            next_dbm       = 1'b1;
                        end
                    end
                    P_DB: begin
                        if (dataChar == CH_M) next_pState = P_DBM;
                    end
                    P_DBM: begin
                        if (dataChar == CH_V) begin
                            next_amplitude = applied;
                            next_db        = 1'b1;
                            next_mv        = 1'b1;
                            next_dbm       = 1'b0;
                        end
                    end
                    default: next_pState = P_IDLE;
                endcase
            end
            // REN release and IFC win over everything above
            if (!busRen) begin
                next_remote  = 1'b0;
                next_lockout = 1'b0;
            end
            if (busIfc) begin
                next_addressed = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            remoteIndicator    <= 1'b0;
            addressedIndicator <= 1'b0;
            lockout            <= 1'b0;
            dbIndicator        <= 1'b0;
            mvIndicator        <= 1'b0;
            dbmIndicator       <= 1'b1;
            amplitude          <= AMP_INIT;
            pState             <= P_IDLE;
            acc                <= 16'h0000;
            neg                <= 1'b0;
            point              <= 1'b0;
            frac               <= 1'b0;
            keyAccept          <= '0;
        end else begin
            remoteIndicator    <= next_remote;
            addressedIndicator <= next_addressed;
            lockout            <= next_lockout;
            dbIndicator        <= next_db;
            mvIndicator        <= next_mv;
            dbmIndicator       <= next_dbm;
            amplitude          <= next_amplitude;
            pState             <= next_pState;
            acc                <= next_acc;
            neg                <= next_neg;
            point              <= next_point;
            frac               <= next_frac;
            keyAccept          <= next_keyAccept;
        end
    end

    // ------------------------------------------------------------
    // register bus slave
    // ------------------------------------------------------------
    logic        awHeld, next_awHeld, wHeld, next_wHeld;
    logic [7:0]  awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic        wLane0, next_wLane0;
    logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [4:0]  next_myAddr;

    always_comb begin
        next_awHeld = awHeld;
        next_wHeld  = wHeld;
        next_awAddr = awAddr;
        next_wData  = wData;
        next_wLane0 = wLane0;
        next_bvalid = s_axi_bvalid;
        next_bresp  = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp  = s_axi_rresp;
        next_rdata  = s_axi_rdata;
        next_myAddr = myAddr;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld  = 1'b1;
            next_wData  = s_axi_wdata;
            next_wLane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (awHeld && wHeld && !s_axi_bvalid) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = RESP_OKAY;
            // control address is the only writable field; status is read-only
            if ({awAddr[7:2], 2'h0} == REG_CTRL) begin
                if (wLane0) next_myAddr = wData[4:0];
            end else if ({awAddr[7:2], 2'h0} != REG_STATUS &&
                         {awAddr[7:2], 2'h0} != REG_AMPL) begin
                next_bresp = RESP_SLVERR;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'h0})
                REG_CTRL:   next_rdata[4:0] = myAddr;
                REG_STATUS: begin
                    next_rdata[ST_REMOTE]  = remoteIndicator;
                    next_rdata[ST_ADDR]    = addressedIndicator;
                    next_rdata[ST_LOCKOUT] = lockout;
                    next_rdata[ST_DBMV]    = mvIndicator;
                end
                REG_AMPL:   next_rdata[15:0] = amplitude;
                default:    next_rresp = RESP_SLVERR;
            endcase
        end
        next_awready = ~next_awHeld & ~next_bvalid;
        next_wready  = ~next_wHeld & ~next_bvalid;
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 8'h00;
            wData         <= 32'h0000_0000;
            wLane0        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            myAddr        <= CTRL_ADDR_RESET;
        end else begin
            awHeld        <= next_awHeld;
            wHeld         <= next_wHeld;
            awAddr        <= next_awAddr;
            wData         <= next_wData;
            wLane0        <= next_wLane0;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
            myAddr        <= next_myAddr;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_unitV;
        dataTaken && !powerResetSwitch && !cmdClear && pState == P_DBM && dataChar == CH_V;
    endsequence
    sequence s_lit_dbmv;
        dbIndicator && mvIndicator && !dbmIndicator;
    endsequence

    a_remote_entry: assert property ($rose(remoteIndicator) |->
        $past(busRen) && $past(listenMine)) else $error("remote without ren and address");
    a_remote_lights: assert property ($rose(remoteIndicator) && !$past(busIfc) |->
        addressedIndicator && $stable(amplitude)) else $error("remote entry wrong");
    a_keys_blocked: assert property (remoteIndicator |=> keyAccept == '0)
        else $error("key passed in remote");
    // other address bytes may still move the addressed state, so they stay out
    a_lockout_hold: assert property (remoteIndicator && lockout && localKey && busRen &&
        !gtlTaken && !powerResetSwitch && !listenMine && !listenOther && !cmdUnl |=>
        remoteIndicator && (addressedIndicator == $past(addressedIndicator) || $past(busIfc)))
        else $error("local key broke lockout");
    a_ren_release: assert property (!busRen |=> !remoteIndicator && !lockout)
        else $error("ren release ignored");
    a_clear_init: assert property (cmdClear && busRen && !busIfc && !powerResetSwitch |=>
        amplitude == AMP_INIT && dbmIndicator && $stable(addressedIndicator))
        else $error("clear did not restore amplitude");
    a_ifc_unaddr: assert property (busIfc |=> !addressedIndicator)
        else $error("ifc left device addressed");
    a_dbmv_units: assert property (s_unitV |=> s_lit_dbmv)
        else $error("dbmv units not lit");
    a_local_addr: assert property (listenMine && !busRen && !busIfc && !powerResetSwitch
        |=> addressedIndicator && !remoteIndicator) else $error("local addressing wrong");
    a_gtl_local: assert property (gtlTaken && !listenMine |=> !remoteIndicator)
        else $error("gtl ignored");
    a_data_gated: assert property (!addressedIndicator && !cmdClear && !powerResetSwitch
        |=> $stable(amplitude)) else $error("data taken while unaddressed");
endmodule : gpibrl_listener

// >>> tb/gpibrl_ctl_model.sv
// bus controller model: drives REN, IFC, ATN and one strobe per byte
// assumes the acceptor handshake is folded into the strobe
`timescale 1ns/1ns
module gpibrl_ctl_model (
    // bus lines
    input  wire logic  clk,
    output logic       ren,
    output logic       ifc,
    output logic       atn,
    output logic       stb,
    output logic [7:0] dat
);
    initial {ren, ifc, atn, stb, dat} = '0;
    // released data lines show the inverse, never a stale byte
    task send(input logic a, input logic [7:0] b);
        @(posedge clk);
        atn <= a;
        dat <= b;
        stb <= 1'b1;
        @(posedge clk);
        stb <= 1'b0;
        dat <= ~b;
        #1;
    endtask : send
    task lines(input logic r, input logic i);
        @(posedge clk);
        ren <= r;
        ifc <= i;
        @(posedge clk);
        #1;
    endtask : lines
endmodule : gpibrl_ctl_model

// >>> tb/gpibrl_listener_tb_top.sv
// bench for the listener block: controller model on the bus, axi master
// assumes the block answers axi within the timeout
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module gpibrl_listener_tb_top import gpibrl_pkg::*;;
    logic sys_clk = 0, sys_rst = 1, localKey = 0, powerResetSwitch = 0;
    logic busRen, busIfc, busAtn, busStrobe, hv, ha, hw;
    logic [7:0] busData, s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [15:0] keyPress = 0, keyAccept, amplitude, kv;
    logic remoteIndicator, addressedIndicator, dbIndicator, mvIndicator, dbmIndicator;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int num_errors = 0, num_checks = 0, seed = 66, cyc = 0;
    int mRem = 0, mAdr = 0, mLok = 0, mMy = CTRL_ADDR_RESET, mb;
    always #25 sys_clk = ~sys_clk;
    gpibrl_ctl_model ctl_u (.clk(sys_clk), .ren(busRen), .ifc(busIfc), .atn(busAtn),
        .stb(busStrobe), .dat(busData));
    gpibrl_listener dut_u (.sys_clk, .sys_rst, .busRen, .busIfc, .busAtn, .busStrobe,
        .busData, .keyPress, .localKey, .powerResetSwitch, .keyAccept, .remoteIndicator,
        .addressedIndicator, .dbIndicator, .mvIndicator, .dbmIndicator, .amplitude,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    task stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {wr, wr, wr};
        {s_axi_arvalid, s_axi_rready} <= {!wr, !wr};
        do begin
            @(negedge sys_clk);
            ha = wr ? s_axi_awready : s_axi_arready;
            hw = s_axi_wready;
            hv = wr ? s_axi_bvalid : s_axi_rvalid;
            {q, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
            @(posedge sys_clk);
            if (ha) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (hw) s_axi_wvalid <= 1'b0;
        end while (!hv);
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask : axi
    task kp(input logic lk, input logic [15:0] m);
        @(posedge sys_clk);
        kv = 16'($random(seed));
        {keyPress, localKey} <= {kv, lk};
        @(posedge sys_clk);
        {keyPress, localKey} <= '0;
        #1;
        `CHK("keys", kv & m, keyAccept)
    endtask : kp
    task ind(input logic er, input logic ea);
        `CHK("rmt", er, remoteIndicator)
        `CHK("adr", ea, addressedIndicator)
        `CHK("model rmt", mRem, remoteIndicator)
        `CHK("model adr", mAdr, addressedIndicator)
    endtask : ind
    task str(input string t);
        for (int i = 0; i < t.len(); i++) begin
            ctl_u.send(0, 8'(($random(seed) & 'h80) | t[i]));
        end
    endtask : str
    // reference model of remote, addressed and lockout, judged on the old state
    always @(posedge sys_clk) begin
        mb = (busStrobe && busAtn) ? (busData & 'h7f) : 'h80;
        if (localKey && mRem && !mLok) mRem = 0;
        if (mb == ('h20 | mMy) && mMy != 'h1f) begin
            mAdr = 1;
            mRem = mRem | busRen;
        end else if (mb >= 'h20 && mb < 'h40) mAdr = 0;
        if (mb == CMD_LLO && busRen) mLok = 1;
        if (mb == CMD_GTL && mAdr) mRem = 0;
        if (!busRen) {mRem, mLok} = '0;
        if (busIfc) mAdr = 0;
        if (sys_rst || powerResetSwitch) {mRem, mAdr, mLok} = '0;
    end
    always @(posedge sys_clk) if (++cyc == 20000) begin num_errors++; stop_test(); end
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 0;
        repeat (2) @(posedge sys_clk);
        ctl_u.send(1, 8'h27); ind(0, 1);
        ctl_u.send(1, 8'h2f); ind(0, 0);
        ctl_u.lines(1, 0); ctl_u.send(1, 8'h27); ind(1, 1);
        kp(1, 16'h0); ind(0, 1);
        kp(0, 16'hffff);
        ctl_u.send(1, {1'b0, CMD_LLO}); ctl_u.send(1, 8'h27); kp(1, 0); ind(1, 1);
        ctl_u.lines(0, 0); ind(0, 1);
        axi(0, REG_STATUS, 0); `CHK("lock", 1'b0, q[ST_LOCKOUT])
        ctl_u.lines(1, 0); ctl_u.send(1, 8'h27); ctl_u.send(1, 8'h45); ind(1, 1);
        str("aP3.0dBmV");
        `CHK("amp", 16'd30, amplitude)
        `CHK("dbmv", 3'b110, {dbIndicator, mvIndicator, dbmIndicator})
        ctl_u.send(1, {1'b0, CMD_DCL}); ind(1, 1); `CHK("amp", AMP_INIT, amplitude)
        `CHK("dbmv", 3'b001, {dbIndicator, mvIndicator, dbmIndicator})
        ctl_u.send(1, {1'b0, CMD_GTL}); ind(0, 1);
        ctl_u.lines(1, 1); ctl_u.lines(1, 0); ind(0, 0);
        str("aP3.0dBmV");
        `CHK("amp", AMP_INIT, amplitude)
        axi(1, REG_CTRL, 32'h5); mMy = 5; `CHK("bresp", RESP_OKAY, r)
        axi(0, REG_CTRL, 0); `CHK("addr", 32'h5, q)
        ctl_u.send(1, 8'h25); ind(1, 1);
        axi(0, 8'h0c, 0); `CHK("rresp", RESP_SLVERR, r)
        str("AP-12.5DM"); `CHK("amp", 16'hff83, amplitude)
        `CHK("dbm", 3'b001, {dbIndicator, mvIndicator, dbmIndicator})
        ctl_u.send(1, {1'b0, CMD_SDC}); `CHK("amp", AMP_INIT, amplitude)
        ctl_u.send(1, {1'b0, CMD_UNL}); ind(1, 0);
        @(posedge sys_clk) powerResetSwitch <= 1;
        @(posedge sys_clk) powerResetSwitch <= 0;
        #1 ind(0, 0);
        stop_test();
    end
endmodule : gpibrl_listener_tb_top
